//--- hw/gli_blinker.sv
`timescale 1ns/100ps
module gli_blinker #(
  parameter int BLINK_CYCLES = gli_pkg::GLI_BLINK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic link_i,
  input wire logic activity_i,
  output logic pull_low_o
);
  typedef struct packed {
    gli_pkg::gli_blink_t st;
    logic [gli_pkg::GLI_CNT_W-1:0] cnt;
    logic pend;
  } gli_blink_state_t;

  localparam logic [gli_pkg::GLI_CNT_W-1:0] LAST = gli_pkg::GLI_CNT_W'(BLINK_CYCLES - 1);

  gli_blink_state_t r;
  gli_blink_state_t next_r;

  // ----------------------------------------------------------------
  // blink sequencer: dark phase, then a lit phase of at least as long
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (!link_i) begin
      next_r.st = gli_pkg::GLI_IDLE;
      next_r.cnt = '0;
      next_r.pend = 1'b0;
    end else begin
      case (r.st)
        gli_pkg::GLI_IDLE: begin
          if (activity_i) begin
            next_r.st = gli_pkg::GLI_DARK;
            next_r.cnt = '0;
          end
        end
        gli_pkg::GLI_DARK: begin
          next_r.cnt = r.cnt + 1'b1;
          if (r.cnt == LAST) begin
            next_r.st = gli_pkg::GLI_LIT;
            next_r.cnt = '0;
            next_r.pend = 1'b0;
          end
        end
        gli_pkg::GLI_LIT: begin
          next_r.cnt = r.cnt + 1'b1;
          next_r.pend = r.pend | activity_i;
          if (r.cnt == LAST) begin
            next_r.cnt = '0;
            next_r.pend = 1'b0;
            next_r.st = (r.pend | activity_i) ? gli_pkg::GLI_DARK : gli_pkg::GLI_IDLE;
          end
        end
        default: begin
          next_r.st = gli_pkg::GLI_IDLE;
          next_r.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r <= '{st: gli_pkg::GLI_IDLE, cnt: '0, pend: 1'b0};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // lit solid while the link is valid, dark only during a blink
  assign pull_low_o = link_i && (r.st != gli_pkg::GLI_DARK);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  dark_length_a: assert property ((r.st == gli_pkg::GLI_DARK) && (next_r.st == gli_pkg::GLI_LIT)
    |-> r.cnt == LAST) else $error("dark phase length wrong");
  lit_minimum_a: assert property ((r.st == gli_pkg::GLI_LIT) && link_i && (next_r.st != gli_pkg::GLI_LIT)
    |-> r.cnt == LAST) else $error("lit phase ended early");
  solid_on_link_a: assert property (ce_i && link_i && (r.st == gli_pkg::GLI_IDLE) && !activity_i
    |=> pull_low_o || !link_i) else $error("link indicator not lit");
endmodule

//--- hw/gli_pkg.sv
package gli_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] GLI_CFG_ADDR = 4'h0;
  localparam logic [3:0] GLI_DATA_ADDR = 4'h4;
  localparam logic [3:0] GLI_STAT_ADDR = 4'h8;
  localparam int GLI_CFG_OE_LSB = 0;
  localparam int GLI_CFG_OD_LSB = 8;
  localparam int GLI_CFG_LED_LSB = 16;
  localparam int GLI_DATA_OUT_LSB = 0;
  localparam int GLI_DATA_IN_LSB = 8;
  localparam logic [2:0] GLI_CFG_OE_RST = 3'h0;
  localparam logic [2:0] GLI_CFG_OD_RST = 3'h0;
  localparam logic [2:0] GLI_CFG_LED_RST = 3'h0;
  localparam logic [2:0] GLI_DATA_OUT_RST = 3'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint GLI_CLK_HZ = 25000000;
  localparam longint GLI_BLINK_MS = 80;
  localparam int GLI_BLINK_CYCLES = int'((GLI_CLK_HZ * GLI_BLINK_MS) / 1000);
  localparam int GLI_CNT_W = 21;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] led;
    logic [2:0] od;
    logic [2:0] oe;
  } gli_cfg_t;
  typedef struct packed {
    logic speed_100;
    logic aneg_busy;
    logic cable_ok;
    logic link_valid;
    logic activity;
    logic full_duplex;
  } gli_link_t;
  typedef enum logic [1:0] {
    GLI_IDLE = 2'b00,
    GLI_DARK = 2'b01,
    GLI_LIT = 2'b10
  } gli_blink_t;
endpackage

//--- hw/gli_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - each of three pins configurable as push-pull output, open-drain output, or input.
// - a pin in indicator role is only ever driven open-drain.
// - speed indicator low at 100 Mb/s, during auto-negotiation, or without cable.
// - speed indicator released high only during 10 Mb/s operation.
// - link-activity indicator held low while link valid and no blink running.
// - activity blinks indicator high 80 ms, then low at least 80 ms, repeating.
// - duplex indicator low only while the link is full duplex.
module gli_top #(
  parameter int BLINK_CYCLES = gli_pkg::GLI_BLINK_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic [3:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  input wire logic [3:0] BYTEENABLE_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  input wire logic SPEED_100_I,
  input wire logic ANEG_BUSY_I,
  input wire logic CABLE_OK_I,
  input wire logic LINK_VALID_I,
  input wire logic ACTIVITY_I,
  input wire logic FULL_DUPLEX_I,
  input wire logic [2:0] INDICATOR_PINS_I,
  output logic [2:0] INDICATOR_PINS_O,
  output logic [2:0] INDICATOR_PINS_OE_O
);
  typedef struct packed {
    gli_pkg::gli_cfg_t cfg;
    logic [2:0] dout;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
  } gli_top_state_t;

  gli_top_state_t r;
  gli_top_state_t next_r;
  gli_pkg::gli_link_t link;
  logic link_pull_low;
  logic speed_n;
  logic link_act_n;
  logic duplex_n;
  logic [2:0] ind_level;
  logic [31:0] cfg_word;
  logic [31:0] data_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // indicator levels (1 = released high, 0 = pulled low)
  // ----------------------------------------------------------------
  assign link = '{speed_100: SPEED_100_I, aneg_busy: ANEG_BUSY_I, cable_ok: CABLE_OK_I,
                  link_valid: LINK_VALID_I, activity: ACTIVITY_I, full_duplex: FULL_DUPLEX_I};

  gli_blinker #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_blinker (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .ce_i(CE_I),
    .link_i(link.link_valid),
    .activity_i(link.activity),
    .pull_low_o(link_pull_low)
  );

  assign speed_n = !link.speed_100 && !link.aneg_busy && link.cable_ok;
  assign link_act_n = !link_pull_low;
  assign duplex_n = !link.full_duplex;
  assign ind_level = {duplex_n, link_act_n, speed_n};

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  always_comb begin
    cfg_word = '0;
    cfg_word[gli_pkg::GLI_CFG_OE_LSB +: 3] = r.cfg.oe;
    cfg_word[gli_pkg::GLI_CFG_OD_LSB +: 3] = r.cfg.od;
    cfg_word[gli_pkg::GLI_CFG_LED_LSB +: 3] = r.cfg.led;
    data_word = '0;
    data_word[gli_pkg::GLI_DATA_OUT_LSB +: 3] = r.dout;
    data_word[gli_pkg::GLI_DATA_IN_LSB +: 3] = INDICATOR_PINS_I;
  end

  // ----------------------------------------------------------------
  // bus slave and pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    next_r = r;
    next_r.ack = 1'b0;
    if ((READ_I || WRITE_I) && !r.ack) begin
      next_r.ack = 1'b1;
      case (ADDRESS_I)
        gli_pkg::GLI_CFG_ADDR: next_r.rdata = cfg_word;
        gli_pkg::GLI_DATA_ADDR: next_r.rdata = data_word;
        gli_pkg::GLI_STAT_ADDR: next_r.rdata = {29'h0, ind_level};
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (WRITE_I && r.ack) begin
      case (ADDRESS_I)
        gli_pkg::GLI_CFG_ADDR: begin
          wv = merge_bytes(cfg_word, WRITEDATA_I, BYTEENABLE_I);
          next_r.cfg.oe = wv[gli_pkg::GLI_CFG_OE_LSB +: 3];
          next_r.cfg.od = wv[gli_pkg::GLI_CFG_OD_LSB +: 3];
          next_r.cfg.led = wv[gli_pkg::GLI_CFG_LED_LSB +: 3];
        end
        gli_pkg::GLI_DATA_ADDR: begin
          wv = merge_bytes(data_word, WRITEDATA_I, BYTEENABLE_I);
          next_r.dout = wv[gli_pkg::GLI_DATA_OUT_LSB +: 3];
        end
        default: begin
          wv = '0;
        end
      endcase
    end
    for (int i = 0; i < 3; i++) begin
      if (r.cfg.led[i]) begin
        // open-drain, general-purpose settings ignored
        next_r.pin_o[i] = 1'b0;
        next_r.pin_oe[i] = !ind_level[i];
      end else if (!r.cfg.oe[i]) begin
        next_r.pin_o[i] = 1'b0;
        next_r.pin_oe[i] = 1'b0;
      end else if (r.cfg.od[i]) begin
        next_r.pin_o[i] = 1'b0;
        next_r.pin_oe[i] = !r.dout[i];
      end else begin
        next_r.pin_o[i] = r.dout[i];
        next_r.pin_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      r <= '{cfg: '{led: gli_pkg::GLI_CFG_LED_RST, od: gli_pkg::GLI_CFG_OD_RST, oe: gli_pkg::GLI_CFG_OE_RST},
             dout: gli_pkg::GLI_DATA_OUT_RST, ack: 1'b0, rdata: 32'h0, pin_o: 3'h0, pin_oe: 3'h0};
    end else if (CE_I) begin
      r <= next_r;
    end
  end

  assign READDATA_O = r.rdata;
  assign WAITREQUEST_O = (READ_I || WRITE_I) && !r.ack;
  assign INDICATOR_PINS_O = r.pin_o;
  assign INDICATOR_PINS_OE_O = r.pin_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence led_pin_s(int i);
    CE_I && r.cfg.led[i];
  endsequence

  speed_pull_low_a: assert property (led_pin_s(0) ##0 (SPEED_100_I || ANEG_BUSY_I || !CABLE_OK_I)
    |=> INDICATOR_PINS_OE_O[0] && !INDICATOR_PINS_O[0]) else $error("speed indicator not pulled low");
  speed_release_a: assert property (led_pin_s(0) ##0 (!SPEED_100_I && !ANEG_BUSY_I && CABLE_OK_I)
    |=> !INDICATOR_PINS_OE_O[0]) else $error("speed indicator not released at 10M");
  duplex_low_a: assert property (led_pin_s(2) |=> INDICATOR_PINS_OE_O[2] == $past(FULL_DUPLEX_I))
    else $error("duplex indicator wrong");
  link_lit_a: assert property (led_pin_s(1) ##0 link_pull_low |=> INDICATOR_PINS_OE_O[1])
    else $error("link indicator not lit");
  led_open_drain_a: assert property (r.cfg.led[0] || r.cfg.led[1] || r.cfg.led[2]
    |-> (INDICATOR_PINS_O & r.cfg.led) == 3'h0) else $error("indicator pin driven high");
  led_override_a: assert property (led_pin_s(1) ##0 (!r.cfg.oe[1] && !LINK_VALID_I)
    |=> !INDICATOR_PINS_OE_O[1] && !INDICATOR_PINS_O[1]) else $error("general settings leak into led");
  push_pull_a: assert property (CE_I && r.cfg == gli_pkg::gli_cfg_t'{led: 3'h0, od: 3'h0, oe: 3'h7}
    |=> INDICATOR_PINS_OE_O == 3'h7 && INDICATOR_PINS_O == $past(r.dout)) else $error("push-pull drive wrong");
  open_drain_a: assert property (CE_I && r.cfg == gli_pkg::gli_cfg_t'{led: 3'h0, od: 3'h7, oe: 3'h7}
    |=> INDICATOR_PINS_O == 3'h0 && INDICATOR_PINS_OE_O == ~$past(r.dout)) else $error("open-drain drive wrong");
  input_mode_a: assert property (CE_I && (r.cfg.led == 3'h0) && (r.cfg.oe == 3'h0)
    |=> INDICATOR_PINS_OE_O == 3'h0) else $error("input pin driven");
  bus_answer_a: assert property (CE_I && READ_I && WAITREQUEST_O |=> !WAITREQUEST_O)
    else $error("bus answer late");
endmodule

//--- sim/gli_board_model.sv
`timescale 1ns/100ps
module gli_board_model (
  input wire logic [2:0] pins_o_i,
  input wire logic [2:0] pins_oe_i,
  output logic [2:0] pins_i_o
);
  // board pull-ups behind the leds: a released pin reads high
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pins_i_o[i] = pins_oe_i[i] ? pins_o_i[i] : 1'b1;
    end
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int BLINK = 8;
  logic clk, rst_n, rd, wr, ce;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata;
  logic waitreq;
  gli_pkg::gli_link_t lk;
  logic [2:0] pins_i, pins_o, pins_oe, dout, oe, od, e_oe, e_o;
  int error_cnt, n_checks, len;
  logic [31:0] exp_q[$];

  gli_top #(.BLINK_CYCLES(BLINK)) gli_top_inst (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata), .BYTEENABLE_I(be),
    .READDATA_O(rdata), .WAITREQUEST_O(waitreq), .SPEED_100_I(lk.speed_100),
    .ANEG_BUSY_I(lk.aneg_busy), .CABLE_OK_I(lk.cable_ok), .LINK_VALID_I(lk.link_valid),
    .ACTIVITY_I(lk.activity), .FULL_DUPLEX_I(lk.full_duplex), .INDICATOR_PINS_I(pins_i),
    .INDICATOR_PINS_O(pins_o), .INDICATOR_PINS_OE_O(pins_oe));
  gli_board_model gli_board_model_inst (.pins_o_i(pins_o), .pins_oe_i(pins_oe), .pins_i_o(pins_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // bus master: hold the request until waitrequest is seen low
  // --------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    int n = 0;
    logic wq;
    if (!w) exp_q.push_back(exp);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(negedge clk);
      wq = waitreq;
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (rd === 1'b1 && waitreq === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("wrong value at %0t: read without note", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  task automatic pins_chk(input logic [2:0] m, input logic [2:0] x_oe, input logic [2:0] x_o);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({29'h0, pins_oe & m}, {29'h0, x_oe & m});
    check({29'h0, pins_o & m}, {29'h0, x_o & m});
    @(posedge clk);
  endtask

  // counts negedges on which the link pin enable holds lvl
  task automatic run_len(input logic lvl);
    int n = 0;
    len = 0;
    while (pins_oe[1] !== lvl && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
    while (pins_oe[1] === lvl && len < 50) begin
      @(negedge clk);
      len++;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    be = 4'hf;
    lk = '0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(73421));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, gli_pkg::GLI_CFG_ADDR, 32'h0, 32'h0);
    bus(1'b0, gli_pkg::GLI_DATA_ADDR, 32'h0, 32'h0000_0700);
    bus(1'b1, 4'hc, 32'hffff_ffff, 32'h0);
    bus(1'b0, 4'hc, 32'h0, 32'h0);
    for (int m = 0; m < 3; m++) begin
      dout = 3'($urandom());
      oe = (m == 0) ? 3'h0 : 3'h7;
      od = (m == 2) ? 3'h7 : 3'h0;
      e_oe = (m == 0) ? 3'h0 : ((m == 1) ? 3'h7 : ~dout);
      e_o = (m == 1) ? dout : 3'h0;
      bus(1'b1, gli_pkg::GLI_DATA_ADDR, {29'h0, dout}, 32'h0);
      bus(1'b1, gli_pkg::GLI_CFG_ADDR, {21'h0, od, 5'h0, oe}, 32'h0);
      pins_chk(3'h7, e_oe, e_o);
      bus(1'b0, gli_pkg::GLI_DATA_ADDR, 32'h0, {21'h0, (e_oe & e_o) | ~e_oe, 5'h0, dout});
    end
    be <= 4'h0;
    bus(1'b1, gli_pkg::GLI_DATA_ADDR, {29'h0, ~dout}, 32'h0);
    be <= 4'hf;
    bus(1'b0, gli_pkg::GLI_DATA_ADDR, 32'h0, {21'h0, dout, 5'h0, dout});
    bus(1'b1, gli_pkg::GLI_DATA_ADDR, 32'h7, 32'h0);
    // pins 0 and 2 would push high, pin 1 would be an input, were the indicator role not set
    bus(1'b1, gli_pkg::GLI_CFG_ADDR, 32'h0007_0005, 32'h0);
    for (int c = 0; c < 8; c++) begin
      lk.speed_100 <= c[0];
      lk.aneg_busy <= c[1];
      lk.cable_ok <= c[2];
      pins_chk(3'h1, {2'h0, !(!c[0] && !c[1] && c[2])}, 3'h0);
    end
    pins_chk(3'h6, 3'h0, 3'h0);
    lk.full_duplex <= 1'b1;
    pins_chk(3'h4, 3'h4, 3'h0);
    // clock enable low: the pins keep their last drive although duplex drops
    ce <= 1'b0;
    lk.full_duplex <= 1'b0;
    pins_chk(3'h4, 3'h4, 3'h0);
    ce <= 1'b1;
    lk.link_valid <= 1'b1;
    pins_chk(3'h6, 3'h2, 3'h0);
    bus(1'b0, gli_pkg::GLI_STAT_ADDR, 32'h0, 32'h4);
    lk.activity <= 1'b1;
    run_len(1'b0);
    check(len, BLINK);
    run_len(1'b1);
    check(len, BLINK);
    @(posedge clk);
    lk.activity <= 1'b0;
    run_len(1'b0);
    check(len, BLINK);
    run_len(1'b1);
    check(len, 50);
    @(posedge clk);
    lk.link_valid <= 1'b0;
    pins_chk(3'h2, 3'h0, 3'h0);
    give_verdict();
  end
endmodule
